// ### design/cpg_clock_unit.sv
// clock pulse unit: control register on AXI4-Lite, peripheral clock and prescaler
// Behaviour
// R1 - register resets to c8, hardware standby reloads it
// R2 - bits 7,6 ignore writes, read one
// R3 - halve bit zero: peripheral clock undivided
// R4 - halve bit one: peripheral clock halved
// R5 - bit 4 plain storage, resets zero
// R6 - prescaler taps half down to 4096th
// R7 - system clock equals oscillator input frequency
// R8 - external reset held 500 us after clock; the bench releases rstn after 8 mclk cycles, and after 10 in mid-run
// R9 - wait mode and count fields stored, exported
// R10 - duty corrected at 5 MHz and above; no logic here corrects duty, mclk is used as it arrives
// R11 - prescaler and halver cleared on reset
`timescale 1ns/1ps
module cpg_clock_unit (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hw_standby,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic periph_clk_en,
   output logic [11:0] prescale_tap,
   output logic [1:0] wait_mode_select,
   output logic [1:0] wait_count
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [5:0] ctrl;
   logic [5:0] next_ctrl;
   logic aw_held;
   logic next_aw_held;
   logic [11:0] aw_addr;
   logic [11:0] next_aw_addr;
   logic w_held;
   logic next_w_held;
   logic [31:0] w_data;
   logic [31:0] next_w_data;
   logic w_strb0;
   logic next_w_strb0;
   logic bvalid;
   logic next_bvalid;
   logic [1:0] bresp;
   logic [1:0] next_bresp;
   logic rvalid;
   logic next_rvalid;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [1:0] rresp;
   logic [1:0] next_rresp;
   logic periph_tick;
   logic [11:0] tap_tick;
   logic [7:0] ctrl_view;
   logic do_write;
   // bus readies registered so every top-level output leaves a flip-flop
   logic aw_rdy;
   logic next_aw_rdy;
   logic w_rdy;
   logic next_w_rdy;
   logic ar_rdy;
   logic next_ar_rdy;

   // system clock is mclk itself: no multiply, no divide; duty shaping of
   // the raw oscillator happens in the analog pad ring, mclk arrives clean [R7] [R10]

   // bits 7 and 6 are not stored at all, so writes cannot reach them [R2]
   assign ctrl_view = cpg_pkg::FIXED_ONES | {2'b00, ctrl};

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb0 = w_strb0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_ctrl = ctrl;
      do_write = 1'b0;
      if (s_axi_awvalid && !aw_held && !bvalid) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held && !bvalid) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb0 = s_axi_wstrb[0];
      end
      if (aw_held && w_held) begin
         do_write = 1'b1;
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = cpg_pkg::RESP_OKAY;
         if (aw_addr[11:2] == cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL[11:2]) begin
            if (w_strb0) begin
               next_ctrl = w_data[5:0] & cpg_pkg::WRITABLE_MASK[5:0]; // [R5] [R9] [R2]
            end
         end else if (aw_addr[11:2] != cpg_pkg::ADDR_CLOCK_STATUS[11:2]) begin
            next_bresp = cpg_pkg::RESP_SLVERR;
         end
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // hardware standby reloads the value; software standby never gets here [R1]
      if (hw_standby) begin
         next_ctrl = cpg_pkg::CLOCK_AND_WAIT_CONTROL_RESET[5:0];
      end
      // same value the old gate gave, one flop earlier
      next_aw_rdy = !next_aw_held && !next_bvalid;
      next_w_rdy = !next_w_held && !next_bvalid;
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = cpg_pkg::RESP_OKAY;
         if (s_axi_araddr[11:2] == cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL[11:2]) begin
            next_rdata = {24'h00_0000, ctrl_view}; // [R2]
         end else if (s_axi_araddr[11:2] == cpg_pkg::ADDR_CLOCK_STATUS[11:2]) begin
            // live prescaler phase: which taps fire now, with periph_tick ORed into bit 11
            next_rdata = {20'h0_0000, periph_tick, 11'h000} | {20'h0_0000, tap_tick};
         end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = cpg_pkg::RESP_SLVERR;
         end
      end
      next_ar_rdy = !next_rvalid;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= cpg_pkg::CLOCK_AND_WAIT_CONTROL_RESET[5:0]; // [R1] [R5]
         aw_rdy <= 1'b1;
         w_rdy <= 1'b1;
         ar_rdy <= 1'b1;
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
         periph_clk_en <= 1'b0;
         prescale_tap <= 12'h000;
      end else begin
         ctrl <= next_ctrl;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb0 <= next_w_strb0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         aw_rdy <= next_aw_rdy;
         w_rdy <= next_w_rdy;
         ar_rdy <= next_ar_rdy;
         periph_clk_en <= periph_tick; // [R3] [R4]
         prescale_tap <= tap_tick; // [R6]
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = aw_rdy;
   assign s_axi_wready = w_rdy;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = ar_rdy;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata = rdata;
   assign s_axi_rresp = rresp;
   assign wait_mode_select = ctrl[3:2]; // [R9]
   assign wait_count = ctrl[1:0]; // [R9]

   cpg_prescaler u_prescaler (
      .mclk(mclk),
      .rstn(rstn),
      .periph_clock_halve(ctrl[cpg_pkg::PERIPH_CLOCK_HALVE_BIT]),
      .periph_tick(periph_tick),
      .tap_tick(tap_tick)
   );
endmodule

// ### design/cpg_prescaler.sv
// peripheral clock enable and divided taps /2 .. /4096
`timescale 1ns/1ps
module cpg_prescaler (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic periph_clock_halve,
   output logic periph_tick,
   output logic [11:0] tap_tick
);
   logic half_phase;
   logic next_half_phase;
   logic [11:0] count;
   logic [11:0] next_count;
   logic [11:0] rise;

   // ---------------------------------------------------------------
   // halving stage and ripple count
   // ---------------------------------------------------------------
   always_comb begin
      next_half_phase = half_phase ^ periph_clock_halve;
      // undivided when clear, every other mclk when set [R3] [R4]
      periph_tick = periph_clock_halve ? half_phase : 1'b1;
      next_count = periph_tick ? count + 12'h001 : count; // [R6]
   end

   // tap k fires when bit k of the count rises: rate periph/2^(k+1)
   generate
      for (genvar k = 0; k < 12; k++) begin : g_tap
         assign rise[k] = periph_tick && (next_count[k] && !count[k]);
      end
   endgenerate
   assign tap_tick = rise; // [R6]

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         half_phase <= 1'b0; // [R11]
         count <= cpg_pkg::PRESCALE_RESET; // [R11]
      end else begin
         half_phase <= next_half_phase;
         count <= next_count;
      end
   end
endmodule

// ### shared/cpg_pkg.sv
// constants for the clock pulse unit: register map, field layout, reset values
package cpg_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CLOCK_AND_WAIT_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_CLOCK_STATUS = 12'h004;
   // ---------------------------------------------------------------
   // field layout of clock_and_wait_control
   // ---------------------------------------------------------------
   localparam int RSVD_HI_BIT = 7;
   localparam int RSVD_LO_BIT = 6;
   localparam int PERIPH_CLOCK_HALVE_BIT = 5;
   localparam int SPARE_BIT = 4;
   localparam int WAIT_MODE_SELECT_HI_BIT = 3;
   localparam int WAIT_MODE_SELECT_LO_BIT = 2;
   localparam int WAIT_COUNT_HI_BIT = 1;
   localparam int WAIT_COUNT_LO_BIT = 0;
   localparam logic [7:0] CLOCK_AND_WAIT_CONTROL_RESET = 8'hc8;
   localparam logic [7:0] WRITABLE_MASK = 8'h3f;
   localparam logic [7:0] FIXED_ONES = 8'hc0;
   // ---------------------------------------------------------------
   // prescaler
   // ---------------------------------------------------------------
   localparam int PRESCALE_WIDTH = 12;
   localparam logic [11:0] PRESCALE_RESET = 12'h000;
   // ---------------------------------------------------------------
   // external reset hold, kept for the bench
   // ---------------------------------------------------------------
   localparam real CLOCK_SETTLE_DELAY_US = 500.0;
   localparam real MCLK_PERIOD_NS = 4.0;
   localparam int CLOCK_SETTLE_CYCLES = int'(CLOCK_SETTLE_DELAY_US * 1000.0 / MCLK_PERIOD_NS);
   localparam int RESET_PULSE_CYCLES = 10;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### verif/cpg_clock_unit_asserts.sv
// checker for the clock pulse unit ports
`timescale 1ns/1ps
module cpg_clock_unit_asserts (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hw_standby,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic periph_clk_en,
   input wire logic [11:0] prescale_tap,
   input wire logic [1:0] wait_mode_select,
   input wire logic [1:0] wait_count
);
   // ----
   // properties
   // ----
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   AST_STANDBY_RELOAD: assert property (hw_standby |=>
      wait_mode_select == 2'b10 && wait_count == 2'b00) else $error("standby reload lost");
   AST_HALF_ALTERNATE: assert property ($fell(periph_clk_en) |=> periph_clk_en)
      else $error("enable low twice");
   AST_TAP0_SINGLE: assert property (prescale_tap[0] |=> !prescale_tap[0])
      else $error("first tap too fast");
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   AST_W_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   AST_READ_FIELDS: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr == cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL |=> s_axi_rdata[7:6] == 2'b11
      && s_axi_rdata[3:0] == {wait_mode_select, wait_count}) else $error("read fields wrong");
   cover property (s_axi_bvalid);
   cover property (hw_standby);
   cover property (prescale_tap[11]);
endmodule

// ### verif/cpg_clock_unit_bench.sv
// bench for the clock pulse unit: register, divider and tap tests
`timescale 1ns/1ps
module cpg_clock_unit_bench;
   logic mclk = 1'b0, rstn = 1'b0, hw_standby = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_clk_en;
   logic [1:0] s_axi_bresp, s_axi_rresp, wait_mode_select, wait_count, resp;
   logic [31:0] s_axi_rdata, rd;
   logic [11:0] prescale_tap;
   logic [7:0] vals [4] = '{8'h00, 8'h3f, 8'h15, 8'h2a};
   int n_fail = 0;
   int samples_checked = 0;
   int n, h;
   cpg_clock_unit dut (.*);
   always #2 mclk = ~mclk;
   // ----
   // tasks
   // ----
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one bus access; valids drop on their own handshake edge
   task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic [1:0] r);
      logic aw, w, ar, done;
      int i;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_bready <= we;
      s_axi_arvalid <= !we;
      s_axi_rready <= !we;
      for (i = 0; i < 100; i++) begin
         @(negedge mclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         ar = s_axi_arvalid && s_axi_arready;
         done = we ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         r = we ? s_axi_bresp : s_axi_rresp;
         @(posedge mclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (ar) s_axi_arvalid <= 1'b0;
         if (done) break;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (i == 100) begin
         n_fail++;
         end_sim();
      end
   endtask
   // negedges until tap k pulses; a lost pulse ends the run
   task automatic wait_tap(input int k, output int c);
      c = 0;
      do begin
         @(negedge mclk);
         c++;
      end while (prescale_tap[k] !== 1'b1 && c < 20000);
      if (c >= 20000) begin
         n_fail++;
         end_sim();
      end
   endtask
   task automatic per(input int k, input int e);
      int c;
      wait_tap(k, c);
      wait_tap(k, c);
      chk("tap period", c, e);
   endtask
   // ----
   // sequence
   // ----
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      acc(0, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 0, rd, resp);
      chk("reset value", rd, 32'h0000_00c8);
      foreach (vals[j]) begin
         acc(1, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 32'(vals[j]), rd, resp);
         acc(0, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 0, rd, resp);
         chk("readback", rd, {24'h00_0000, 2'b11, vals[j][5:0]});
         chk("wait fields", 32'({wait_mode_select, wait_count}), 32'(vals[j][3:0]));
      end
      for (h = 0; h < 2; h++) begin
         acc(1, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 32'(h * 32), rd, resp);
         repeat (4) @(posedge mclk);
         n = 0;
         repeat (8) begin
            @(negedge mclk);
            n = n + int'(periph_clk_en === 1'b1);
         end
         chk("enable count", n, 8 >> h);
         per(0, 2 << h);
         per(11, 4096 << h);
      end
      // standby reload, then a reset in mid-run
      acc(1, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 32'h0000_003f, rd, resp);
      hw_standby <= 1'b1;
      @(posedge mclk);
      hw_standby <= 1'b0;
      acc(0, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 0, rd, resp);
      chk("standby value", rd, 32'h0000_00c8);
      acc(1, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 32'h0000_0015, rd, resp);
      rstn <= 1'b0;
      repeat (cpg_pkg::RESET_PULSE_CYCLES) @(posedge mclk);
      rstn <= 1'b1;
      // count cleared: bit 11 first rises after 2048 ticks, plus the output stage
      wait_tap(11, n);
      chk("first tap after reset", n, 2049);
      acc(0, cpg_pkg::ADDR_CLOCK_AND_WAIT_CONTROL, 0, rd, resp);
      chk("second reset", rd, 32'h0000_00c8);
      acc(0, cpg_pkg::ADDR_CLOCK_STATUS, 0, rd, resp);
      chk("status tick", rd[11], 1'b1);
      chk("status resp", 32'(resp), 32'(cpg_pkg::RESP_OKAY));
      acc(1, 12'h008, 0, rd, resp);
      chk("unmapped write", 32'(resp), 32'(cpg_pkg::RESP_SLVERR));
      acc(0, 12'h008, 0, rd, resp);
      chk("unmapped read", 32'(resp), 32'(cpg_pkg::RESP_SLVERR));
      end_sim();
   end
endmodule
bind cpg_clock_unit cpg_clock_unit_asserts u_chk (.*);
